// ---- quad_count_pkg.sv ----
// Constants and carriers for the quadrature event counter.
// Assumes a single 40 MHz clock domain; no software bus, controls are ports.
package quad_count_pkg;
    localparam int COUNT_WIDTH = 16;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_MIN = 16'h0000;
    localparam logic [1:0] SYNC_RESET = 2'h0;

    // Control levels, held by software
    typedef struct packed {
        logic count_start;
        logic fourfold_edge_select;
        logic count_type_select;
    } quad_ctrl_s;

    // Host write strobe with its data
    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } quad_write_s;

    typedef enum logic [1:0] {
        STEP_NONE = 2'b00,
        STEP_UP = 2'b01,
        STEP_DOWN = 2'b10
    } step_e;
endpackage

// ---- quadrature_event_counter.sv ----
// Quadrature event counter: two phase pins drive a 16-bit up/down counter.
// Assumes phase pins synchronous-ish to clock; controls and the register port are plain ports.
// How it works
// - Pulse interrupt on overflow up or underflow down
// - Read port shows live count
// - Stopped write loads reload and counter
// - Running write loads only reload register
// - Normal: B high, A rise up, fall down
// - x4: A rises with B high, count up
// - x4: A falls with B high, count down
// - Wrap reloads unless free-run selected
// - Count only while start flag set
// - Edge select 0 normal, 1 x4
`timescale 1ns/1ps
module quadrature_event_counter
    import quad_count_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire quad_count_pkg::quad_ctrl_s ctrl,
    input wire quad_count_pkg::quad_write_s count_write,
    output logic [15:0] quad_count_register,
    output logic [15:0] reload_value,
    output logic interrupt_request
);
    import quad_count_pkg::*;

    // ********************************
    // Input synchronisers and edges
    // ********************************
    logic [1:0] sync_a_reg, sync_a_next;
    logic [1:0] sync_b_reg, sync_b_next;
    logic prev_a_reg, prev_a_next;
    logic prev_b_reg, prev_b_next;
    logic dir_up_reg, dir_up_next;

    always_comb
    begin
        sync_a_next = {sync_a_reg[0], phase_a_input};
        sync_b_next = {sync_b_reg[0], phase_b_input};
        prev_a_next = sync_a_reg[1];
        prev_b_next = sync_b_reg[1];
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_a_reg <= SYNC_RESET;
            sync_b_reg <= SYNC_RESET;
            prev_a_reg <= 1'b0;
            prev_b_reg <= 1'b0;
            dir_up_reg <= 1'b1;
        end
        else
        begin
            sync_a_reg <= sync_a_next;
            sync_b_reg <= sync_b_next;
            prev_a_reg <= prev_a_next;
            prev_b_reg <= prev_b_next;
            dir_up_reg <= dir_up_next;
        end
    end

    logic a_now, b_now, a_rise, a_fall, a_edge, b_edge;
    assign a_now = sync_a_reg[1];
    assign b_now = sync_b_reg[1];
    assign a_rise = a_now & ~prev_a_reg;
    assign a_fall = ~a_now & prev_a_reg;
    assign a_edge = a_rise | a_fall;
    assign b_edge = b_now ^ prev_b_reg;

    // ********************************
    // Step decode
    // ********************************
    step_e step;

    always_comb
    begin
        step = STEP_NONE;
        dir_up_next = dir_up_reg;
        if (!ctrl.fourfold_edge_select)
        begin
            if (b_now && a_rise)
                step = STEP_UP;
            else if (b_now && a_fall)
                step = STEP_DOWN;
        end
        else
        begin
            // Direction latched by A edges while B high; applies to all edges
            if (a_edge && b_now)
                dir_up_next = a_rise;
            if (a_edge || b_edge)
                step = dir_up_next ? STEP_UP : STEP_DOWN;
        end
        if (!ctrl.count_start)
            step = STEP_NONE;
    end

    // ********************************
    // Counter, reload and interrupt
    // ********************************
    logic [15:0] count_reg, count_next;
    logic [15:0] reload_reg, reload_next;
    logic irq_reg, irq_next;

    always_comb
    begin
        count_next = count_reg;
        reload_next = reload_reg;
        irq_next = 1'b0;
        case (step)
            STEP_UP:
            begin
                if (count_reg == COUNT_MAX)
                begin
                    irq_next = 1'b1;
                    // Free-run simply wraps
                    count_next = ctrl.count_type_select ? COUNT_MIN : reload_reg;
                end
                else
                    count_next = count_reg + 16'h0001;
            end
            STEP_DOWN:
            begin
                if (count_reg == COUNT_MIN)
                begin
                    irq_next = 1'b1;
                    count_next = ctrl.count_type_select ? COUNT_MAX : reload_reg;
                end
                else
                    count_next = count_reg - 16'h0001;
            end
            default:
                count_next = count_reg;
        endcase
        if (count_write.valid)
        begin
            reload_next = count_write.data;
            // A write while stopped overrides the counter too
            if (!ctrl.count_start)
                count_next = count_write.data;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            count_reg <= COUNT_RESET;
            reload_reg <= COUNT_RESET;
            irq_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            reload_reg <= reload_next;
            irq_reg <= irq_next;
        end
    end

    assign quad_count_register = count_reg;
    assign reload_value = reload_reg;
    assign interrupt_request = irq_reg;

    // ********************************
    // Assertions
    // ********************************
    AST_IRQ_WRAP: assert property (@(posedge clock) disable iff (!resetn)
        interrupt_request |-> ($past(step) == STEP_UP && $past(count_reg) == COUNT_MAX)
        || ($past(step) == STEP_DOWN && $past(count_reg) == COUNT_MIN))
        else $error("interrupt without wrap");
    AST_STOPPED_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        (count_write.valid && !ctrl.count_start) |=> (count_reg == $past(count_write.data)
        && reload_reg == $past(count_write.data)))
        else $error("stopped write not loaded");
    AST_RUNNING_WRITE: assert property (@(posedge clock) disable iff (!resetn)
        (count_write.valid && ctrl.count_start && step == STEP_NONE)
        |=> (reload_reg == $past(count_write.data) && $stable(count_reg)))
        else $error("running write touched counter");
    AST_NORMAL_UP: assert property (@(posedge clock) disable iff (!resetn)
        (ctrl.count_start && !ctrl.fourfold_edge_select && b_now && a_rise
        && count_reg != COUNT_MAX && !count_write.valid)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("normal up count missed");
    AST_NORMAL_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        (!ctrl.fourfold_edge_select && !b_now && !count_write.valid) |=> $stable(count_reg))
        else $error("normal count with B low");
    AST_X4_UP: assert property (@(posedge clock) disable iff (!resetn)
        (ctrl.count_start && ctrl.fourfold_edge_select && b_now && a_rise
        && count_reg != COUNT_MAX && !count_write.valid)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("x4 up count missed");
    AST_X4_DOWN: assert property (@(posedge clock) disable iff (!resetn)
        (ctrl.count_start && ctrl.fourfold_edge_select && b_now && a_fall
        && count_reg != COUNT_MIN && !count_write.valid)
        |=> count_reg == $past(count_reg) - 16'h0001)
        else $error("x4 down count missed");
    AST_RELOAD: assert property (@(posedge clock) disable iff (!resetn)
        (step == STEP_UP && count_reg == COUNT_MAX && !ctrl.count_type_select
        && !count_write.valid) |=> count_reg == $past(reload_reg))
        else $error("no reload on overflow");
    AST_STOP_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        (!ctrl.count_start && !count_write.valid) |=> ($stable(count_reg) && !interrupt_request))
        else $error("counted while stopped");
    AST_SYNC_DELAY: assert property (@(posedge clock) disable iff (!resetn)
        $rose(phase_a_input) ##1 phase_a_input |=> a_now)
        else $error("sync path delay wrong");

    COV_OVERFLOW: cover property (@(posedge clock) disable iff (!resetn) interrupt_request);
    COV_X4_DOWN: cover property (@(posedge clock) disable iff (!resetn)
        ctrl.fourfold_edge_select && step == STEP_DOWN);
    COV_FREE_RUN: cover property (@(posedge clock) disable iff (!resetn)
        ctrl.count_type_select && interrupt_request);
    COV_RUN_WRITE: cover property (@(posedge clock) disable iff (!resetn)
        ctrl.count_start && count_write.valid);
endmodule

// ---- quad_source.sv ----
// Two-phase pulse source standing in for an encoder.
// Assumes one step request at a time, with idle cycles between.
`timescale 1ns/1ps
module quad_source (
    input wire logic clock,
    input wire logic resetn,
    input wire logic step,
    input wire logic dir_up,
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] pos_reg;
    // Gray order, one pin moves per step
    assign phase_a = pos_reg[1];
    assign phase_b = pos_reg[1] ^ pos_reg[0];
    always_ff @(posedge clock or negedge resetn)
        if (!resetn)
            pos_reg <= 2'h0;
        else if (step)
            pos_reg <= dir_up ? pos_reg + 2'h1 : pos_reg - 2'h1;
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the quadrature event counter.
// Assumes the handover latencies; a bench model queues expected values.
`timescale 1ns/1ps
module tb_top;
    import quad_count_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic step = 1'b0;
    logic dir_up = 1'b1;
    logic phase_a, phase_b, interrupt_request, x4_up = 1'b1;
    quad_ctrl_s ctrl = '0;
    quad_write_s count_write = '0;
    logic [15:0] quad_count_register, reload_value;
    logic [15:0] exp_cnt = 16'h0000, exp_rel = 16'h0000;
    logic [15:0] prev_cnt = 16'h0000, prev_rel = 16'h0000;
    logic [32:0] notes[$];
    int miscompares = 0, checked = 0, cycles = 0, i;
    int seed = 32'h2d97862d;
    quad_source src (.clock(clock), .resetn(resetn), .step(step), .dir_up(dir_up),
        .phase_a(phase_a), .phase_b(phase_b));
    quadrature_event_counter dut (.clock(clock), .resetn(resetn), .phase_a_input(phase_a),
        .phase_b_input(phase_b), .ctrl(ctrl), .count_write(count_write),
        .quad_count_register(quad_count_register), .reload_value(reload_value),
        .interrupt_request(interrupt_request));
    initial forever #12.5 clock = ~clock;
    // ****************
    // Tasks
    // ****************
    task automatic check(input logic [32:0] seen, input logic [32:0] want);
        checked++;
        if (seen !== want)
        begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [15:0] d);
        @(posedge clock);
        count_write <= '{valid: 1'b1, data: d};
        @(posedge clock);
        count_write <= '0;
        exp_rel = d;
        if (!ctrl.count_start)
            exp_cnt = d;
        notes.push_back({1'b0, exp_rel, exp_cnt});
        repeat (3) @(posedge clock);
    endtask
    task automatic bump(input logic up);
        logic wrap;
        wrap = up ? exp_cnt == 16'hFFFF : exp_cnt == 16'h0000;
        if (wrap && !ctrl.count_type_select)
            exp_cnt = exp_rel;
        else
            exp_cnt = up ? exp_cnt + 16'h0001 : exp_cnt - 16'h0001;
        notes.push_back({wrap, exp_rel, exp_cnt});
    endtask
    task automatic mv(input logic up);
        logic [1:0] npos;
        // Wait an edge first so a ctrl change made just before is seen
        @(posedge clock);
        npos = {phase_a, phase_a ^ phase_b} + (up ? 2'h1 : 2'h3);
        if (ctrl.count_start && ctrl.fourfold_edge_select)
        begin
            // B never moves with A, so B is the level at an A edge
            if (npos[1] != phase_a && phase_b)
                x4_up = npos[1];
            bump(x4_up);
        end
        else if (ctrl.count_start && npos[1] != phase_a && phase_b)
            bump(npos[1]);
        step <= 1'b1;
        dir_up <= up;
        @(posedge clock);
        step <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
    // ****************
    // Monitor and sequence
    // ****************
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            miscompares++;
            report_and_stop();
        end
        if (quad_count_register !== prev_cnt || reload_value !== prev_rel || interrupt_request)
            check({interrupt_request, reload_value, quad_count_register},
                notes.size() ? notes.pop_front() : 33'bx);
        prev_cnt = quad_count_register;
        prev_rel = reload_value;
    end
    initial
    begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        check({interrupt_request, reload_value, quad_count_register}, 33'h0);
        wr({2'b01, 14'($random(seed))});
        ctrl <= '{1'b1, 1'b0, 1'b0};
        for (i = 0; i < 24; i++)
            mv(1'($random(seed)));
        wr(16'h1234);
        ctrl <= '0;
        wr(16'hFFFF);
        ctrl <= '{1'b1, 1'b0, 1'b0};
        wr(16'h0ABC);
        repeat (4) mv(1'b1);
        ctrl <= '0;
        repeat (4) mv(1'b1);
        while ({phase_a, phase_b} != 2'b01)
            mv(1'b1);
        check({1'b0, reload_value, quad_count_register}, {1'b0, exp_rel, exp_cnt});
        wr(16'h0002);
        ctrl <= '{1'b1, 1'b1, 1'b1};
        mv(1'b1);
        repeat (6) mv(1'b0);
        for (i = 0; i < 16; i++)
            mv(1'($random(seed)));
        repeat (8) @(posedge clock);
        check(33'(notes.size()), 33'h0);
        report_and_stop();
    end
endmodule
